// *** hdl/gpx_pkg.sv ***
// constants and types shared by the eight-pin port with function mux
// assumes a single 100 MHz clock domain and full-word register access
`default_nettype none

package gpx_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NPINS  = 8;
  localparam int unsigned NIB_W  = 4;   // one nibble per pin in drive and function registers
  localparam int unsigned DRV_W  = 2;
  localparam int unsigned FSEL_W = 3;

  // ---------------------------------------------------------------
  // register byte addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_PORT_DATA  = 32'h5c004500;
  localparam logic [31:0] ADDR_PORT_DIR   = 32'h5c004504;
  localparam logic [31:0] ADDR_DRIVE_CFG  = 32'h5c004508;
  localparam logic [31:0] ADDR_FUNC_SEL   = 32'h5c00450c;
  localparam logic [7:0]  RST_PORT_DATA   = 8'h00;
  localparam logic [7:0]  RST_PORT_DIR    = 8'h00;
  localparam logic [1:0]  RST_DRIVE_FIELD = 2'h0;
  localparam logic [2:0]  RST_FUNC_FIELD  = 3'h0;

  // direction bit values
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN  = 1'b1;

  // pins that carry a function timer output in the quaternary slot
  localparam logic [7:0] QUA_PIN_MASK   = 8'hcc;
  localparam int unsigned PIN_TMR_CLK_A = 6;
  localparam int unsigned PIN_TMR_CLK_B = 7;

  // drive field: output meaning / input meaning
  typedef enum logic [1:0] {DRV_HIZ, DRV_PDRAIN, DRV_NDRAIN, DRV_CMOS} gpx_drive_t;

  // decoded pin function
  typedef enum logic [2:0] {FN_GPIO, FN_SEC, FN_TER, FN_QUA, FN_LCD} gpx_func_t;

  // function field decode; any code with the top bit set selects the lcd segment
  function automatic gpx_func_t fn_decode(input logic [2:0] code);
    gpx_func_t f;
    f = FN_GPIO;
    case (code[2:1])
      2'h0:    f = code[0] ? FN_SEC : FN_GPIO;
      2'h1:    f = code[0] ? FN_QUA : FN_TER;
      default: f = FN_LCD;
    endcase
    return f;
  endfunction

endpackage

`default_nettype wire

// *** hdl/gpx_port.sv ***
// eight-pin general-purpose port with per-pin drive type and function mux
// assumes pin inputs already synchronous to ref_clk; pad cells resolve oe/out/pulls
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module gpx_port (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  // board-side pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out_q,
  output logic      [7:0]  pin_oe_q,
  output logic      [7:0]  pin_pull_up_q,
  output logic      [7:0]  pin_pull_dn_q,
  // core side, values towards the pins
  input  wire logic [7:0]  sec_func_out,
  input  wire logic [7:0]  ter_func_out,
  input  wire logic [3:0]  func_timer_out,
  input  wire logic [7:0]  lcd_seg_out,
  // core side, sampled pin levels towards peripherals
  output logic      [7:0]  ext_irq_in_q,
  output logic             timer_clk_in_a_q,
  output logic             timer_clk_in_b_q,
  output logic      [7:0]  sec_func_in_q,
  output logic      [7:0]  ter_func_in_q
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0]      data_q;
  logic [7:0]      dir_q;
  logic [7:0][1:0] drv_q;
  logic [7:0][2:0] fsel_q;
  logic [7:0]      pin_q;          // sampled pin level
  logic [31:0]     drv_word;
  logic [31:0]     fsel_word;
  logic [31:0]     rdata_d;
  logic [7:0]      data_view;
  logic [7:0]      out_d;
  logic [7:0]      oe_d;
  logic [7:0]      pu_d;
  logic [7:0]      pd_d;
  logic [7:0]      val_d;          // value the pin would show before drive type
  logic            wr_data;
  logic            wr_dir;
  logic            wr_drv;
  logic            wr_fsel;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // full address compare; the block has no other way to reject stray accesses
  assign wr_data = reg_wr && (reg_addr == gpx_pkg::ADDR_PORT_DATA);
  assign wr_dir  = reg_wr && (reg_addr == gpx_pkg::ADDR_PORT_DIR);
  assign wr_drv  = reg_wr && (reg_addr == gpx_pkg::ADDR_DRIVE_CFG);
  assign wr_fsel = reg_wr && (reg_addr == gpx_pkg::ADDR_FUNC_SEL);

  // data register: stored for all bits, only shown for output pins
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      data_q <= gpx_pkg::RST_PORT_DATA;
    else if (wr_data)
      data_q <= reg_wdata[7:0];
  end

  // direction register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      dir_q <= gpx_pkg::RST_PORT_DIR;
    else if (wr_dir)
      dir_q <= reg_wdata[7:0];
  end

  // pin level sample, shared by data reads and peripheral inputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pin_q <= 8'h00;
    else
      pin_q <= pin_in;
  end

  // ---------------------------------------------------------------
  // per-pin fields and drive logic
  // ---------------------------------------------------------------
  for (genvar n = 0; n < gpx_pkg::NPINS; n++)
  begin : g_pin
    gpx_pkg::gpx_func_t  fn;
    gpx_pkg::gpx_drive_t drv;

    // drive field; reserved bits of the write are dropped
    always_ff @(posedge ref_clk or negedge nrst)
    begin
      if (!nrst)
        drv_q[n] <= gpx_pkg::RST_DRIVE_FIELD;
      else if (wr_drv)
        drv_q[n] <= reg_wdata[n*gpx_pkg::NIB_W +: gpx_pkg::DRV_W];
    end

    // function field
    always_ff @(posedge ref_clk or negedge nrst)
    begin
      if (!nrst)
        fsel_q[n] <= gpx_pkg::RST_FUNC_FIELD;
      else if (wr_fsel)
        fsel_q[n] <= reg_wdata[n*gpx_pkg::NIB_W +: gpx_pkg::FSEL_W];
    end

    // packed readback, reserved bits forced to zero
    assign drv_word[n*gpx_pkg::NIB_W +: gpx_pkg::NIB_W]  = {2'h0, drv_q[n]};
    assign fsel_word[n*gpx_pkg::NIB_W +: gpx_pkg::NIB_W] = {1'h0, fsel_q[n]};
    assign data_view[n] = (dir_q[n] == gpx_pkg::DIR_IN) ? pin_q[n] : data_q[n];

    assign fn  = gpx_pkg::fn_decode(fsel_q[n]);
    assign drv = gpx_pkg::gpx_drive_t'(drv_q[n]);

    // value source: gpio data or the selected peripheral
    always_comb
    begin
      case (fn)
        gpx_pkg::FN_GPIO: val_d[n] = data_q[n];
        gpx_pkg::FN_SEC:  val_d[n] = sec_func_out[n];
        gpx_pkg::FN_TER:  val_d[n] = ter_func_out[n];
        // a prohibited code forces 0 so p-channel drain floats and n-channel and push-pull drive low
        gpx_pkg::FN_QUA:  val_d[n] = gpx_pkg::QUA_PIN_MASK[n] ?
                                     func_timer_out[(n / 4) * 2 + (n % 2)] : 1'b0;
        gpx_pkg::FN_LCD:  val_d[n] = lcd_seg_out[n];
        default:          val_d[n] = 1'b0;
      endcase
    end

    // drive type: output mode shapes oe, input mode only sets pulls
    always_comb
    begin
      out_d[n] = 1'b0;
      oe_d[n]  = 1'b0;
      pu_d[n]  = 1'b0;
      pd_d[n]  = 1'b0;
      if (dir_q[n] == gpx_pkg::DIR_IN)
      begin
        pu_d[n] = (drv == gpx_pkg::DRV_NDRAIN);
        pd_d[n] = (drv == gpx_pkg::DRV_PDRAIN);
      end
      else
      begin
        case (drv)
          gpx_pkg::DRV_HIZ:    oe_d[n] = 1'b0;
          gpx_pkg::DRV_PDRAIN:
          begin
            out_d[n] = 1'b1;                         // only ever pulls high
            oe_d[n]  = val_d[n];
          end
          gpx_pkg::DRV_NDRAIN:
          begin
            out_d[n] = 1'b0;                         // only ever pulls low
            oe_d[n]  = ~val_d[n];
          end
          gpx_pkg::DRV_CMOS:
          begin
            out_d[n] = val_d[n];
            oe_d[n]  = 1'b1;
          end
          default:             oe_d[n] = 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  // registered to keep pad timing clean; costs one cycle after a write
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out_q     <= 8'h00;
      pin_oe_q      <= 8'h00;
      pin_pull_up_q <= 8'h00;
      pin_pull_dn_q <= 8'h00;
    end
    else
    begin
      pin_out_q     <= out_d;
      pin_oe_q      <= oe_d;
      pin_pull_up_q <= pu_d;
      pin_pull_dn_q <= pd_d;
    end
  end

  // ---------------------------------------------------------------
  // peripheral inputs
  // ---------------------------------------------------------------
  // each peripheral sees the pin only while its function is selected;
  // direction is not checked here, software sets input mode first
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_irq_in_q     <= 8'h00;
      timer_clk_in_a_q <= 1'b0;
      timer_clk_in_b_q <= 1'b0;
      sec_func_in_q    <= 8'h00;
      ter_func_in_q    <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < gpx_pkg::NPINS; i++)
      begin
        ext_irq_in_q[i]  <= pin_q[i] && (gpx_pkg::fn_decode(fsel_q[i]) == gpx_pkg::FN_GPIO);
        sec_func_in_q[i] <= pin_q[i] && (gpx_pkg::fn_decode(fsel_q[i]) == gpx_pkg::FN_SEC);
        ter_func_in_q[i] <= pin_q[i] && (gpx_pkg::fn_decode(fsel_q[i]) == gpx_pkg::FN_TER);
      end
      timer_clk_in_a_q <= pin_q[gpx_pkg::PIN_TMR_CLK_A] &&
                          (gpx_pkg::fn_decode(fsel_q[gpx_pkg::PIN_TMR_CLK_A]) == gpx_pkg::FN_GPIO);
      timer_clk_in_b_q <= pin_q[gpx_pkg::PIN_TMR_CLK_B] &&
                          (gpx_pkg::fn_decode(fsel_q[gpx_pkg::PIN_TMR_CLK_B]) == gpx_pkg::FN_GPIO);
    end
  end

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  // unmapped addresses read as zero; data stands only in the cycle after the strobe
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        gpx_pkg::ADDR_PORT_DATA: rdata_d = {24'h000000, data_view};
        gpx_pkg::ADDR_PORT_DIR:  rdata_d = {24'h000000, dir_q};
        gpx_pkg::ADDR_DRIVE_CFG: rdata_d = drv_word;
        gpx_pkg::ADDR_FUNC_SEL:  rdata_d = fsel_word;
        default:                 rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_q <= 32'h00000000;
    else
      reg_rdata_q <= rdata_d;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  for (genvar k = 0; k < gpx_pkg::NPINS; k++)
  begin : g_chk
    // push-pull gpio output follows the data bit one cycle later
    a_cmos_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h3 && fsel_q[k] == 3'h0)
      |=> (pin_oe_q[k] && pin_out_q[k] == $past(data_q[k])))
      else $error("push-pull pin does not follow data");

    // n-channel open drain only ever drives low
    a_ndrain_low: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h2)
      |=> (pin_out_q[k] == 1'b0 && pin_oe_q[k] == !$past(val_d[k])))
      else $error("n-channel drain drives wrongly");

    // input mode never drives and pulls match the drive field
    a_input_pulls: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dir_q[k] == gpx_pkg::DIR_IN)
      |=> (!pin_oe_q[k] && pin_pull_up_q[k] == ($past(drv_q[k]) == 2'h2)
           && pin_pull_dn_q[k] == ($past(drv_q[k]) == 2'h1)))
      else $error("input mode drive or pull wrong");

    // prohibited code never drives high
    a_prohib_low: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!gpx_pkg::QUA_PIN_MASK[k] && fsel_q[k] == 3'h3 && dir_q[k] == gpx_pkg::DIR_OUT)
      |=> !(pin_oe_q[k] && pin_out_q[k]))
      else $error("prohibited function drives high");

    // lcd function carries the segment line on push-pull
    a_lcd_route: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fsel_q[k][2] && dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h3)
      |=> pin_out_q[k] == $past(lcd_seg_out[k]))
      else $error("lcd segment not routed");

    // interrupt input tracks the sampled pin in primary function
    a_irq_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fsel_q[k] == 3'h0) |=> ext_irq_in_q[k] == $past(pin_q[k]))
      else $error("interrupt input does not track pin");

    // p-channel open drain only ever drives high
    a_pdrain_high: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h1)
      |=> (pin_out_q[k] == 1'b1 && pin_oe_q[k] == $past(val_d[k])))
      else $error("p-channel drain drives wrongly");

    // secondary function output reaches the pad on push-pull
    a_sec_route: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fsel_q[k] == 3'h1 && dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h3)
      |=> pin_out_q[k] == $past(sec_func_out[k]))
      else $error("secondary function not routed");

    // tertiary function output reaches the pad on push-pull
    a_ter_route: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fsel_q[k] == 3'h2 && dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h3)
      |=> pin_out_q[k] == $past(ter_func_out[k]))
      else $error("tertiary function not routed");

    // timer outputs a..d belong to pins 2, 3, 6 and 7 in that order
    localparam int TIDX = (k == 2) ? 0 : (k == 3) ? 1 : (k == 6) ? 2 : 3;
    a_timer_route: assert property (@(posedge ref_clk) disable iff (!nrst)
      (gpx_pkg::QUA_PIN_MASK[k] && fsel_q[k] == 3'h3 && dir_q[k] == gpx_pkg::DIR_OUT && drv_q[k] == 2'h3)
      |=> pin_out_q[k] == $past(func_timer_out[TIDX]))
      else $error("timer output not routed");

    // secondary input sees the pin while the interrupt input is gated off
    a_sec_input: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fsel_q[k] == 3'h1) |=> (sec_func_in_q[k] == $past(pin_q[k]) && !ext_irq_in_q[k]))
      else $error("secondary input not routed");
  end

  // timer clock inputs follow pins 6 and 7 in primary function
  a_tclk_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
    (fsel_q[gpx_pkg::PIN_TMR_CLK_A] == 3'h0 && fsel_q[gpx_pkg::PIN_TMR_CLK_B] == 3'h0)
    |=> (timer_clk_in_a_q == $past(pin_q[gpx_pkg::PIN_TMR_CLK_A])
         && timer_clk_in_b_q == $past(pin_q[gpx_pkg::PIN_TMR_CLK_B])))
    else $error("timer clock input does not track pin");

  // data read of an input pin shows the pin level one cycle after it was seen
  a_read_input: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_rd && reg_addr == gpx_pkg::ADDR_PORT_DATA && dir_q == 8'hff)
    |=> reg_rdata_q == {24'h000000, $past(pin_q)})
    else $error("input read not the pin level");

  // a write to the data register reads back for output pins
  a_read_back: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_wr && reg_addr == gpx_pkg::ADDR_PORT_DATA && dir_q == 8'h00 && !wr_dir)
    ##1 (reg_rd && reg_addr == gpx_pkg::ADDR_PORT_DATA)
    |=> reg_rdata_q[7:0] == $past(reg_wdata[7:0], 2))
    else $error("data write does not read back");

  // reserved bits always read zero, whichever register was addressed
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($past(reg_addr) == gpx_pkg::ADDR_DRIVE_CFG) ? ((reg_rdata_q & 32'hcccccccc) == 32'h00000000) :
    ($past(reg_addr) == gpx_pkg::ADDR_FUNC_SEL)  ? ((reg_rdata_q & 32'h88888888) == 32'h00000000) :
    (reg_rdata_q[31:8] == 24'h000000))
    else $error("reserved bit read as one");

  // read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !$past(reg_rd) |-> reg_rdata_q == 32'h00000000)
    else $error("read data outside read cycle");

endmodule // gpx_port

`default_nettype wire

// *** hdl/gpx_port_unused.sv ***
`timescale 1ns/10ps

// *** tb/gpx_pad_model.sv ***
// board-side pad model for the eight port pins
// assumes the bench sets the board drivers; a pin nobody drives or pulls wanders
`timescale 1ns/10ps
`default_nettype none

module gpx_pad_model (
  // clock
  input  wire logic       ref_clk,
  // pad controls from the port
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_dn,
  // board drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  logic [7:0] flt_q = 8'h55;

  // a floating pin toggles so that a stale level never passes for a real one
  always @(posedge ref_clk)
  begin
    flt_q <= ~flt_q;
  end

  // pad driver first, then board, then pull resistors
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pin_pull_up[i])
        pin_level[i] = 1'b1;
      else if (pin_pull_dn[i])
        pin_level[i] = 1'b0;
      else
        pin_level[i] = flt_q[i];
    end
  end
endmodule // gpx_pad_model
`default_nettype wire

// *** tb/gpx_port_bench.sv ***
// self-checking bench for the eight-pin port with function mux
// assumes the pad model on the pins and bench-driven peripheral lines
`timescale 1ns/10ps
`default_nettype none

module gpx_port_bench;
  localparam logic [31:0] A_DAT = gpx_pkg::ADDR_PORT_DATA;
  localparam logic [31:0] A_DIR = gpx_pkg::ADDR_PORT_DIR;
  localparam logic [31:0] A_DRV = gpx_pkg::ADDR_DRIVE_CFG;
  localparam logic [31:0] A_FN  = gpx_pkg::ADDR_FUNC_SEL;
  logic        ref_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic [31:0] reg_addr  = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  ext_en    = 8'h00;
  logic [7:0]  ext_val   = 8'h00;
  logic [7:0]  sec_out   = 8'h3c;
  logic [7:0]  ter_out   = 8'h69;
  logic [3:0]  tmr_out   = 4'h9;
  logic [7:0]  lcd_out   = 8'h5a;
  logic [31:0] rdata;
  logic [7:0]  lvl, p_out, p_oe, p_up, p_dn, irq_in, sec_in, ter_in;
  logic        tclk_a, tclk_b;
  int          err_total = 0;
  int          compares  = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  gpx_port DUT (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .pin_in(lvl), .pin_out_q(p_out),
    .pin_oe_q(p_oe), .pin_pull_up_q(p_up), .pin_pull_dn_q(p_dn), .sec_func_out(sec_out),
    .ter_func_out(ter_out), .func_timer_out(tmr_out), .lcd_seg_out(lcd_out), .ext_irq_in_q(irq_in),
    .timer_clk_in_a_q(tclk_a), .timer_clk_in_b_q(tclk_b), .sec_func_in_q(sec_in), .ter_func_in_q(ter_in));

  gpx_pad_model pads (.ref_clk(ref_clk), .pin_out(p_out), .pin_oe(p_oe), .pin_pull_up(p_up),
    .pin_pull_dn(p_dn), .ext_en(ext_en), .ext_val(ext_val), .pin_level(lvl));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 check(rdata, exp, what);
  endtask

  // write then read back in the very next cycle, strobes back to back
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    #1 check(rdata, exp, what);
  endtask

  // registers reach the pins one edge later, peripheral inputs two more
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk(A_DAT, 32'h0, "data reset");
    rd_chk(A_DIR, 32'h0, "dir reset");
    rd_chk(A_DRV, 32'h0, "drive reset");
    rd_chk(A_FN, 32'h0, "func reset");
    check({p_oe, p_up, p_dn}, 24'h0, "pads at reset");
    $display("test reset done");
  endtask

  // every field set, reserved bits written as zero as software must; unmapped address ignored
  task automatic t_regs;
    wr_rd(A_DAT, 32'h000000ff, 32'h000000ff, "data readback");
    wr(A_DIR, 32'h000000ff);
    wr(A_DRV, 32'h33333333);
    wr(A_FN, 32'h77777777);
    wr(A_FN + 32'h4, 32'hffffffff);
    rd_chk(A_DIR, 32'h000000ff, "dir readback");
    rd_chk(A_DRV, 32'h33333333, "drive fields");
    rd_chk(A_FN, 32'h77777777, "func fields");
    rd_chk(A_FN + 32'h4, 32'h0, "unmapped read");
    $display("test registers done");
  endtask

  // every output drive code on pattern a5
  task automatic t_drive;
    logic [7:0] eoe;
    logic [7:0] eo;
    wr(A_FN, 32'h0);
    wr(A_DIR, 32'h0);
    wr(A_DAT, 32'ha5);
    for (int c = 0; c < 4; c++)
    begin
      wr(A_DRV, {8{2'h0, c[1:0]}});
      settle;
      eoe = (c == 0) ? 8'h00 : (c == 1) ? 8'ha5 : (c == 2) ? 8'h5a : 8'hff;
      eo  = (c == 1 || c == 3) ? 8'ha5 : 8'h00;
      check(p_oe, eoe, "output enable");
      check(p_out & p_oe, eo, "driven level");
      check(lvl & p_oe, eo, "pin level");
    end
    $display("test drive done");
  endtask

  // pulls in input mode, then a board-driven level read back
  task automatic t_input;
    wr(A_DIR, 32'hff);
    // codes 00 and 11 leave the pin floating, so only the pulled codes are read back
    for (int c = 0; c < 4; c++)
    begin
      wr(A_DRV, {8{2'h0, c[1:0]}});
      settle;
      check({p_oe, p_up, p_dn}, (c == 2) ? 24'h00ff00 : (c == 1) ? 24'h0000ff : 24'h000000, "input pulls");
      if (c == 1 || c == 2)
        rd_chk(A_DAT, (c == 2) ? 32'hff : 32'h00, "pulled level");
    end
    @(posedge ref_clk);
    ext_en  <= 8'hff;
    ext_val <= 8'h96;
    settle;
    rd_chk(A_DAT, 32'h96, "input read");
    check({irq_in, tclk_b, tclk_a}, 10'h25a, "primary inputs");
    $display("test input done");
  endtask

  // function codes 0 to 2 on the input side, then every code on the output side
  task automatic t_func;
    logic [7:0] e;
    for (int c = 0; c < 3; c++)
    begin
      wr(A_FN, {8{1'b0, c[2:0]}});
      settle;
      check({irq_in, sec_in, ter_in}, 24'h96 << (16 - 8 * c), "input routing");
    end
    @(posedge ref_clk);
    ext_en <= 8'h00;
    wr(A_DIR, 32'h0);
    wr(A_DRV, 32'h33333333);
    for (int c = 0; c < 8; c++)
    begin
      wr(A_FN, {8{1'b0, c[2:0]}});
      settle;
      e = (c == 0) ? 8'ha5 : (c == 1) ? sec_out : (c == 2) ? ter_out : (c == 3) ? 8'h84 : lcd_out;
      check(p_out, e, "function output");
    end
    $display("test functions done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_drive;
    t_input;
    t_func;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    stop_test;
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    stop_test;
  end
endmodule // gpx_port_bench
`default_nettype wire
